// ---- logic/pin_irq_pkg.sv ----
package pin_irq_pkg;
    localparam int PIN_COUNT = 3;
    localparam int FIRST_PIN = 3;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 16;
    localparam int REG_W = 16;
    localparam int IDX_W = 14;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PIN3_CONFIG = 14'h0702;
    localparam logic [IDX_W-1:0] IDX_PIN4_CONFIG = 14'h0703;
    localparam logic [IDX_W-1:0] IDX_PIN5_CONFIG = 14'h0704;
    localparam logic [IDX_W-1:0] IDX_PULL_ONE = 14'h0720;
    localparam logic [IDX_W-1:0] IDX_PULL_TWO = 14'h0721;
    localparam logic [IDX_W-1:0] IDX_PIN_FLAGS = 14'h0730;
    localparam logic [IDX_W-1:0] IDX_CORE_FLAGS = 14'h0731;
    localparam logic [IDX_W-1:0] IDX_CORE_LIVE = 14'h0732;
    localparam logic [IDX_W-1:0] IDX_PIN_MASK = 14'h0738;
    localparam logic [IDX_W-1:0] IDX_CORE_MASK = 14'h0739;

    // Pin configuration fields
    localparam int DIR_BIT = 15;
    localparam int PU_BIT = 14;
    localparam int PD_BIT = 13;
    localparam int POL_BIT = 10;
    localparam int OD_BIT = 9;
    localparam int DB_BIT = 8;
    localparam int LVL_BIT = 6;
    localparam int FN_LSB = 0;
    localparam int FN_W = 4;
    localparam logic [REG_W-1:0] PIN_CFG_RESET = 16'hA101;
    localparam logic [REG_W-1:0] PIN_CFG_WMASK = 16'hE74F;

    localparam logic [REG_W-1:0] PULL_ONE_RESET = 16'h0000;
    localparam logic [REG_W-1:0] PULL_ONE_WMASK = 16'h17FF;
    localparam logic [REG_W-1:0] PULL_TWO_RESET = 16'h0140;
    localparam logic [REG_W-1:0] PULL_TWO_WMASK = 16'h017F;

    // Interrupt layouts
    localparam int PIN_FLAG_LSB = 2;
    localparam logic [REG_W-1:0] PIN_FLAG_BITS = 16'h001C;
    localparam logic [REG_W-1:0] CORE_FLAG_BITS = 16'h1ECF;
    localparam logic [REG_W-1:0] CORE_BOTH_EDGES = 16'h0004;
    localparam logic [REG_W-1:0] CORE_LIVE_BITS = 16'h1EC4;
    localparam logic [REG_W-1:0] MASK_RESET = 16'hFFFF;

    // Function select codes
    typedef enum logic [3:0] {
        FN_NONE = 4'h0, FN_GPIO = 4'h1, FN_IRQ = 4'h2, FN_MIC = 4'h3,
        FN_HP = 4'h4, FN_DYN1 = 4'h5, FN_DYN2 = 4'h6, FN_FIFO = 4'h7,
        FN_SEQ = 4'h8, FN_CAL01 = 4'h9, FN_CAL23 = 4'hA, FN_CLKSW = 4'hB,
        FN_LOCK = 4'hC, FN_OPCLK = 4'hD, FN_LOOPCLK = 4'hE, FN_RSVD = 4'hF
    } pin_fn_t;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- logic/pin_irq_block.sv ----
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module pin_irq_block #(
    parameter int DEBOUNCE_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [pin_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pin_irq_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pin_irq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pin_irq_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] pin_in,
    output logic [pin_irq_pkg::PIN_COUNT-1:0] pin_out,
    output logic [pin_irq_pkg::PIN_COUNT-1:0] pin_oe,
    output logic [pin_irq_pkg::PIN_COUNT-1:0] weak_high_bias_enable,
    output logic [pin_irq_pkg::PIN_COUNT-1:0] weak_low_bias_enable,
    output logic [pin_irq_pkg::REG_W-1:0] pad_pull_one,
    output logic [pin_irq_pkg::REG_W-1:0] pad_pull_two,
    input wire logic mic_detect,
    input wire logic headphone_detect_done,
    input wire logic [1:0] dynamics_activity,
    input wire logic core_buffer_error,
    input wire logic sequencer_idle,
    input wire logic [1:0] offset_cal_complete,
    input wire logic clock_switch_done,
    input wire logic loop_lock,
    input wire logic opclk,
    input wire logic loop_clk,
    output logic irq
);
    import pin_irq_pkg::*;

    generate
        if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 65535) begin : g_bad_param
            $error("DEBOUNCE_CYCLES must lie between 1 and 65535");
        end
    endgenerate

    localparam logic [15:0] DB_LAST = 16'(DEBOUNCE_CYCLES - 1);

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [REG_W-1:0] pin_cfg_reg [PIN_COUNT];
    logic [REG_W-1:0] pin_flags_reg;
    logic [REG_W-1:0] core_flags_reg;
    logic [REG_W-1:0] pin_mask_reg;
    logic [REG_W-1:0] core_mask_reg;
    logic [REG_W-1:0] core_prev_reg;
    logic [PIN_COUNT-1:0] pin_level_reg;
    logic [PIN_COUNT-1:0] pin_level_prev_reg;

    //////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic [IDX_W-1:0] wr_idx;
    logic [REG_W-1:0] wr_bits;
    logic [REG_W-1:0] wr_en_bits;
    logic wr_hit;

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_idx = awaddr_reg[ADDR_W-1:2];
    assign wr_en_bits = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign wr_bits = wdata_reg[REG_W-1:0];

    assign wr_hit = wr_idx inside {IDX_PIN3_CONFIG, IDX_PIN4_CONFIG, IDX_PIN5_CONFIG, IDX_PULL_ONE, IDX_PULL_TWO,
                                   IDX_PIN_FLAGS, IDX_CORE_FLAGS, IDX_CORE_LIVE, IDX_PIN_MASK, IDX_CORE_MASK};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_val,
                                               input logic [REG_W-1:0] new_val,
                                               input logic [REG_W-1:0] lanes,
                                               input logic [REG_W-1:0] wmask);
        logic [REG_W-1:0] sel;
        sel = lanes & wmask;
        merge = (old_val & ~sel) | (new_val & sel);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Pad pull controls
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pad_pull_one <= PULL_ONE_RESET;
            pad_pull_two <= PULL_TWO_RESET;
        end else if (do_write) begin
            if (wr_idx == IDX_PULL_ONE) begin
                pad_pull_one <= merge(pad_pull_one, wr_bits, wr_en_bits, PULL_ONE_WMASK);
            end
            if (wr_idx == IDX_PULL_TWO) begin
                pad_pull_two <= merge(pad_pull_two, wr_bits, wr_en_bits, PULL_TWO_WMASK);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Masks
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_mask_reg <= MASK_RESET;
            core_mask_reg <= MASK_RESET;
        end else if (do_write) begin
            if (wr_idx == IDX_PIN_MASK) begin
                pin_mask_reg <= merge(pin_mask_reg, wr_bits, wr_en_bits, PIN_FLAG_BITS);
            end
            if (wr_idx == IDX_CORE_MASK) begin
                core_mask_reg <= merge(core_mask_reg, wr_bits, wr_en_bits, CORE_FLAG_BITS);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Per-pin configuration, input conditioning and drive
    logic [15:0] fn_src;
    assign fn_src = {1'b0, loop_clk, opclk, loop_lock, clock_switch_done, offset_cal_complete[1],
                     offset_cal_complete[0], sequencer_idle, core_buffer_error, dynamics_activity[1],
                     dynamics_activity[0], headphone_detect_done, mic_detect, irq, 1'b0, 1'b0};

    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p++) begin : g_pin
            logic [2:0] sync_reg;
            logic stable_reg;
            logic [15:0] db_cnt_reg;
            logic [IDX_W-1:0] my_idx;
            logic [FN_W-1:0] fn;
            logic src;
            logic drive_en;
            logic drive_val;

            assign my_idx = IDX_PIN3_CONFIG + IDX_W'(p);
            assign fn = pin_cfg_reg[p][FN_LSB +: FN_W];

            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    pin_cfg_reg[p] <= PIN_CFG_RESET;
                end else if (do_write && wr_idx == my_idx) begin
                    pin_cfg_reg[p] <= merge(pin_cfg_reg[p], wr_bits, wr_en_bits, PIN_CFG_WMASK);
                end
            end

            // Change accepted once the second and third stages agree
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    sync_reg <= '0;
                    stable_reg <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[1:0], pin_in[p]};
                    if (sync_reg[1] == sync_reg[2]) begin
                        stable_reg <= sync_reg[2];
                    end
                end
            end

            // Debounce: new level must hold for DEBOUNCE_CYCLES
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    db_cnt_reg <= '0;
                    pin_level_reg[p] <= 1'b0;
                end else if (!pin_cfg_reg[p][DB_BIT] || stable_reg == pin_level_reg[p]) begin
                    db_cnt_reg <= '0;
                    pin_level_reg[p] <= stable_reg;
                end else if (db_cnt_reg >= DB_LAST) begin
                    db_cnt_reg <= '0;
                    pin_level_reg[p] <= stable_reg;
                end else begin
                    db_cnt_reg <= db_cnt_reg + 16'h0001;
                end
            end

            always_comb begin
                src = (fn == FN_GPIO) ? pin_cfg_reg[p][LVL_BIT] : fn_src[fn];
                drive_val = src ^ pin_cfg_reg[p][POL_BIT];
                drive_en = !pin_cfg_reg[p][DIR_BIT] && fn != FN_NONE && fn != FN_RSVD;
            end

            // Open drain only pulls low; CMOS drives both levels
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    pin_out[p] <= 1'b0;
                    pin_oe[p] <= 1'b0;
                    weak_high_bias_enable[p] <= 1'b0;
                    weak_low_bias_enable[p] <= 1'b1;
                end else begin
                    pin_out[p] <= drive_val && !pin_cfg_reg[p][OD_BIT];
                    pin_oe[p] <= drive_en && (!pin_cfg_reg[p][OD_BIT] || !drive_val);
                    weak_high_bias_enable[p] <= pin_cfg_reg[p][PU_BIT];
                    weak_low_bias_enable[p] <= pin_cfg_reg[p][PD_BIT];
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Event flags: set wins over a clearing write in the same cycle
    logic [REG_W-1:0] core_live;
    logic [REG_W-1:0] core_set;
    logic [REG_W-1:0] pin_set;
    logic [REG_W-1:0] pin_clr;
    logic [REG_W-1:0] core_clr;
    // No core edge in the first cycle: an event already high at reset is not news
    logic primed_reg;

    assign core_live = {3'b000, offset_cal_complete[1], offset_cal_complete[0], sequencer_idle,
                        core_buffer_error, 1'b0, dynamics_activity[1], dynamics_activity[0], 2'b00,
                        clock_switch_done, loop_lock, headphone_detect_done, mic_detect};
    assign core_set = ((core_live & ~core_prev_reg) | (~core_live & core_prev_reg & CORE_BOTH_EDGES))
                      & CORE_FLAG_BITS & {REG_W{primed_reg}};
    assign pin_set = REG_W'(pin_level_reg ^ pin_level_prev_reg) << PIN_FLAG_LSB;
    assign pin_clr = (do_write && wr_idx == IDX_PIN_FLAGS) ? (wr_bits & wr_en_bits) : '0;
    assign core_clr = (do_write && wr_idx == IDX_CORE_FLAGS) ? (wr_bits & wr_en_bits) : '0;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_prev_reg <= '0;
            pin_level_prev_reg <= '0;
            primed_reg <= 1'b0;
        end else begin
            core_prev_reg <= core_live;
            pin_level_prev_reg <= pin_level_reg;
            primed_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_flags_reg <= '0;
            core_flags_reg <= '0;
        end else begin
            pin_flags_reg <= ((pin_flags_reg & ~pin_clr) | pin_set) & PIN_FLAG_BITS;
            core_flags_reg <= ((core_flags_reg & ~core_clr) | core_set) & CORE_FLAG_BITS;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pin_flags_reg & ~pin_mask_reg) || |(core_flags_reg & ~core_mask_reg);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read channel
    logic [IDX_W-1:0] rd_idx;
    logic [REG_W-1:0] rd_val;
    logic rd_hit;

    assign rd_idx = s_axi_araddr[ADDR_W-1:2];

    function automatic logic [REG_W-1:0] cfg_view(input logic [REG_W-1:0] cfg, input logic level);
        logic [REG_W-1:0] v;
        v = cfg;
        v[LVL_BIT] = level ^ cfg[POL_BIT];
        cfg_view = v;
    endfunction

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (rd_idx)
            IDX_PIN3_CONFIG: rd_val = cfg_view(pin_cfg_reg[0], pin_level_reg[0]);
            IDX_PIN4_CONFIG: rd_val = cfg_view(pin_cfg_reg[1], pin_level_reg[1]);
            IDX_PIN5_CONFIG: rd_val = cfg_view(pin_cfg_reg[2], pin_level_reg[2]);
            IDX_PULL_ONE: rd_val = pad_pull_one;
            IDX_PULL_TWO: rd_val = pad_pull_two;
            IDX_PIN_FLAGS: rd_val = pin_flags_reg;
            IDX_CORE_FLAGS: rd_val = core_flags_reg;
            IDX_CORE_LIVE: rd_val = core_live & CORE_LIVE_BITS;
            IDX_PIN_MASK: rd_val = pin_mask_reg & PIN_FLAG_BITS;
            IDX_CORE_MASK: rd_val = core_mask_reg & CORE_FLAG_BITS;
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= DATA_W'(rd_val);
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ---- bench/pin_irq_props.sv ----
module pin_irq_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [pin_irq_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] weak_low_bias_enable,
    input wire logic [pin_irq_pkg::REG_W-1:0] pad_pull_one,
    input wire logic [pin_irq_pkg::REG_W-1:0] pad_pull_two,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import pin_irq_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    sequence both_taken;
        s_axi_awready && s_axi_wready;
    endsequence
    sequence answer_held;
        s_axi_bvalid && $stable(s_axi_bresp);
    endsequence
    ////////////////////////////////////////
    AST_RESET_STATE: assert property ($rose(rstn) |-> pin_oe == 3'b000 && weak_low_bias_enable == 3'b111
        && pad_pull_two == PULL_TWO_RESET && pad_pull_one == PULL_ONE_RESET && !irq) else $error("bad state after reset");
    AST_PULL_BY_WRITE: assert property (($changed(pad_pull_one) || $changed(pad_pull_two))
        |-> $rose(s_axi_bvalid)) else $error("pull enables changed without a write");
    AST_WRITE_ANSWER: assert property (both_taken |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    AST_BRESP_HELD: assert property (s_axi_bvalid && !s_axi_bready |=> answer_held) else $error("bresp dropped");
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready not a pulse");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    AST_RDATA_HELD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("rdata dropped");
    AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule

// ---- bench/pad_model.sv ----
module pad_model (
    input wire logic sys_clk,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] pin_out,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] weak_high,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] weak_low,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] ext_val,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] ext_en,
    output logic [pin_irq_pkg::PIN_COUNT-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import pin_irq_pkg::*;
    logic [PIN_COUNT-1:0] float_reg = 3'b000;
    // An undriven, unbiased pad wanders every cycle
    always_ff @(posedge sys_clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (weak_high[i]) pin_in[i] = 1'b1;
            else if (weak_low[i]) pin_in[i] = 1'b0;
            else pin_in[i] = float_reg[i];
        end
    end
endmodule

// ---- bench/gpio_pins_and_irq_status_test.sv ----
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
module gpio_pins_and_irq_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pin_irq_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [DATA_W-1:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] pin_in, pin_out, pin_oe, weak_high, weak_low, ext_val = 3'b000, ext_en = 3'b000;
    logic [15:0] pad_pull_one, pad_pull_two, src = 16'h0000;
    int err_total = 0, compares = 0, cycles = 0;
    // Core flag bit raised by each routed source code
    localparam logic [15:0] FLAG_OF [0:15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0040,
        16'h0080, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h0008, 16'h0004, 16'h0000, 16'h0000, 16'h0000};
    always #5 sys_clk = ~sys_clk;
    pin_irq_block #(.DEBOUNCE_CYCLES(2)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .weak_high_bias_enable(weak_high),
        .weak_low_bias_enable(weak_low), .pad_pull_one(pad_pull_one), .pad_pull_two(pad_pull_two),
        .mic_detect(src[3]), .headphone_detect_done(src[4]), .dynamics_activity(src[6:5]),
        .core_buffer_error(src[7]), .sequencer_idle(src[8]), .offset_cal_complete(src[10:9]),
        .clock_switch_done(src[11]), .loop_lock(src[12]), .opclk(src[13]), .loop_clk(src[14]), .irq(irq));
    pad_model pads (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .weak_high(weak_high),
        .weak_low(weak_low), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    ////////////////////////////////////////
    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] e, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
        `CHK("rdata", e, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rd(IDX_PIN3_CONFIG, 32'h0000A101, RESP_OKAY);
        rd(IDX_PIN5_CONFIG, 32'h0000A101, RESP_OKAY);
        rd(IDX_PULL_ONE, 32'h00000000, RESP_OKAY);
        rd(IDX_PULL_TWO, 32'h00000140, RESP_OKAY);
        rd(IDX_PIN_FLAGS, 32'h00000000, RESP_OKAY);
        rd(IDX_CORE_FLAGS, 32'h00000000, RESP_OKAY);
        rd(14'h0100, 32'h00000000, RESP_SLVERR);
        wr(14'h0100, 16'hFFFF, RESP_SLVERR);
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic t_drive();
        wr(IDX_PIN3_CONFIG, 16'h0041, RESP_OKAY);
        repeat (8) @(posedge sys_clk);
        `CHK("pin_out", 2'b11, {pin_out[0], pin_oe[0]})
        rd(IDX_PIN3_CONFIG, 32'h00000041, RESP_OKAY);
        wr(IDX_PIN3_CONFIG, 16'h0441, RESP_OKAY);
        repeat (8) @(posedge sys_clk);
        `CHK("pin_out", 1'b0, pin_out[0])
        rd(IDX_PIN3_CONFIG, 32'h00000441, RESP_OKAY);
        wr(IDX_PIN3_CONFIG, 16'h4241, RESP_OKAY);
        repeat (8) @(posedge sys_clk);
        `CHK("pin_oe", 2'b01, {pin_oe[0], weak_high[0]})
        rd(IDX_PIN3_CONFIG, 32'h00004241, RESP_OKAY);
        wr(IDX_PIN3_CONFIG, 16'hA101, RESP_OKAY);
        wr(IDX_PULL_ONE, 16'hFFFF, RESP_OKAY);
        wr(IDX_PULL_TWO, 16'h0000, RESP_OKAY);
        `CHK("pulls", {16'h17FF, 16'h0000}, {pad_pull_one, pad_pull_two})
        rd(IDX_PULL_ONE, 32'h000017FF, RESP_OKAY);
    endtask
    task automatic t_edges();
        wr(IDX_PIN_FLAGS, 16'h001C, RESP_OKAY);
        @(posedge sys_clk);
        ext_val <= 3'b010;
        ext_en <= 3'b010;
        repeat (15) @(posedge sys_clk);
        rd(IDX_PIN4_CONFIG, 32'h0000A141, RESP_OKAY);
        rd(IDX_PIN_FLAGS, 32'h00000008, RESP_OKAY);
        wr(IDX_PIN_FLAGS, 16'h0000, RESP_OKAY);
        rd(IDX_PIN_FLAGS, 32'h00000008, RESP_OKAY);
        wr(IDX_PIN_MASK, 16'hFFF7, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        `CHK("irq", 1'b1, irq)
        wr(IDX_PIN_FLAGS, 16'h0008, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        `CHK("irq", 1'b0, irq)
        ext_val <= 3'b000;
        repeat (15) @(posedge sys_clk);
        rd(IDX_PIN_FLAGS, 32'h00000008, RESP_OKAY);
        `CHK("irq", 1'b1, irq)
        wr(IDX_PIN5_CONFIG, 16'h0002, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        `CHK("pin_out", 1'b1, pin_out[2])
        wr(IDX_PIN_FLAGS, 16'h0008, RESP_OKAY);
        wr(IDX_PIN_MASK, 16'hFFFF, RESP_OKAY);
        `CHK("pin_out", 1'b0, pin_out[2])
    endtask
    task automatic t_core();
        for (int c = 3; c < 15; c++) begin
            wr(IDX_PIN5_CONFIG, 16'(c), RESP_OKAY);
            src <= 16'h0001 << c;
            repeat (4) @(posedge sys_clk);
            `CHK("pin_out", 1'b1, pin_out[2])
            rd(IDX_CORE_LIVE, {16'h0000, FLAG_OF[c] & CORE_LIVE_BITS}, RESP_OKAY);
            rd(IDX_CORE_FLAGS, {16'h0000, FLAG_OF[c]}, RESP_OKAY);
            wr(IDX_CORE_FLAGS, 16'hFFFF, RESP_OKAY);
            src <= 16'h0000;
            repeat (4) @(posedge sys_clk);
            `CHK("pin_out", 1'b0, pin_out[2])
            rd(IDX_CORE_FLAGS, {16'h0000, (c == 12) ? 16'h0004 : 16'h0000}, RESP_OKAY);
            wr(IDX_CORE_FLAGS, 16'hFFFF, RESP_OKAY);
        end
        src <= 16'hFFFF;
        wr(IDX_PIN5_CONFIG, 16'h0000, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        `CHK("pin_oe", 1'b0, pin_oe[2])
        wr(IDX_PIN5_CONFIG, 16'h000F, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        `CHK("pin_oe", 1'b0, pin_oe[2])
        src <= 16'h0000;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_drive();
        t_edges();
        t_core();
        stop_test();
    end
endmodule
bind pin_irq_block pin_irq_props props (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_oe(pin_oe),
    .weak_low_bias_enable(weak_low_bias_enable), .pad_pull_one(pad_pull_one), .pad_pull_two(pad_pull_two), .irq(irq));
